// *** rtl/cedf_pkg.sv ***
// Constants for the CCD event detector and serial word framer.
// Assumes one pixel-rate clock and a host on a simple register port.
package cedf_pkg;
	localparam logic [7:0] CEDF_REG_CTRL = 8'h00;
	localparam logic [7:0] CEDF_REG_THRESH = 8'h04;
	localparam logic [7:0] CEDF_REG_OFFSET = 8'h08;
	localparam logic [7:0] CEDF_REG_WINPOS = 8'h0C;
	localparam logic [7:0] CEDF_REG_WINSIZE = 8'h10;
	localparam logic [7:0] CEDF_REG_STATUS = 8'h14;
	localparam logic [7:0] CEDF_REG_TIMER = 8'h18;
	localparam logic [7:0] CEDF_REG_PAT = 8'h40;
	localparam int CEDF_CTRL_LEN80 = 3;
	localparam int CEDF_CTRL_OVSCAN = 4;
	localparam int CEDF_CTRL_CHKOUT = 5;
	localparam logic [5:0] CEDF_CTRL_RST = 6'h00;
	localparam logic [11:0] CEDF_THRESH_RST = 12'h000;
	localparam logic [11:0] CEDF_OFFSET_RST = 12'h000;
	localparam int CEDF_NPAT = 31;
	localparam int CEDF_CENTER = 12;
	localparam logic [4:0] CEDF_UNCLASS = 5'h1F;
	localparam logic [2:0] CEDF_TRL_MODE = 3'h7;
	localparam logic [6:0] CEDF_LEN64 = 7'h40;
	localparam logic [6:0] CEDF_LEN80 = 7'h50;
	typedef enum logic [2:0] {
		CEDF_IDLE,
		CEDF_HDR,
		CEDF_RUN,
		CEDF_EVT,
		CEDF_TRL
	} cedf_state_t;
endpackage

// *** rtl/cedf_framer.sv ***
// Event qualification, 3x3 classification and serial word framing.
// Assumes an upstream window generator presenting each pixel with its
// 5x5 neighbourhood, and a host register port with one-cycle strobes.
//
// Implementation choices: the address map and strobed register access.
`timescale 1ns/1ps
module cedf_framer
	import cedf_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic frame_start,
	input wire logic [2:0] chip_id,
	input wire logic frame_end,
	input wire logic pix_valid,
	input wire logic pix_qual,
	input wire logic [10:0] pix_x,
	input wire logic [9:0] pix_y,
	input wire logic [24:0][11:0] pix_nbhd,
	input wire logic [24:0] pix_dead,
	output logic in_ready,
	output logic ser_data,
	output logic ser_frame,
	output logic ser_start
);
	typedef struct packed {
		cedf_state_t st;
		logic [79:0] sh;
		logic [6:0] cnt;
		logic sdata;
		logic sframe;
		logic sstart;
		logic rdy;
		logic [31:0] rdata;
		logic [5:0] ctrl;
		logic [11:0] thr;
		logic [11:0] ofs;
		logic [20:0] wpos;
		logic [20:0] wsz;
		logic [30:0][8:0] pat;
		logic [2:0] chip;
		logic [15:0] evc;
		logic [31:0] tmr;
	} cedf_core_t;

	cedf_core_t state_reg;
	cedf_core_t state_next;
	logic [24:0][11:0] corr;
	logic [24:0] hit;
	logic [7:0] sig;
	logic [16:0] pattern_energy_sum;
	logic [16:0] inner_ring_energy_sum;
	logic [16:0] outer_ring_energy_sum;
	logic [5:0] psel;
	logic locmax;
	logic [4:0] code;
	logic qual;
	logic keep;
	logic len80;
	logic ovs;
	logic chk;
	logic [6:0] lenm1;
	logic ld;
	logic [79:0] ldw;
	cedf_state_t ldst;
	logic acc_pix;
	logic acc_end;
	logic acc_start;

	function automatic logic is_inner(input int i);
		return (i / 5 >= 1) && (i / 5 <= 3) && (i % 5 >= 1) && (i % 5 <= 3)
			&& (i != CEDF_CENTER);
	endfunction

	function automatic logic [16:0] sat(input logic [16:0] v, input int w);
		logic [16:0] lim;
		lim = 17'((32'h1 << w) - 32'h1);
		return (v > lim) ? lim : v;
	endfunction

	// Bit 5 flags a hit in the pattern table window, low bits give the entry
	function automatic logic [5:0] pat_sel(input logic [ADDR_W-1:0] a);
		logic [7:0] off;
		off = 8'(a) - CEDF_REG_PAT;
		if (8'(a) >= CEDF_REG_PAT && off[1:0] == 2'h0 && off[7:2] < 6'(CEDF_NPAT)) begin
			return {1'b1, off[6:2]};
		end else begin
			return 6'h00;
		end
	endfunction

	function automatic logic [20:0] pos21(input logic o, input logic [20:0] p);
		return o ? p : {1'b0, p[19:0]};
	endfunction

	assign len80 = state_reg.ctrl[CEDF_CTRL_LEN80];
	assign ovs = state_reg.ctrl[CEDF_CTRL_OVSCAN];
	assign chk = state_reg.ctrl[CEDF_CTRL_CHKOUT];
	assign psel = pat_sel(reg_addr);
	assign lenm1 = (len80 ? CEDF_LEN80 : CEDF_LEN64) - 7'h01;
	assign acc_start = frame_start && state_reg.rdy && state_reg.st == CEDF_IDLE;
	assign acc_end = frame_end && state_reg.rdy && state_reg.st == CEDF_RUN;
	assign acc_pix = pix_valid && state_reg.rdy && state_reg.st == CEDF_RUN && !frame_end;

	// Pixel path: dead removal, offset, threshold, proximity and pattern
	always_comb begin
		int k;
		k = 0;
		sig = 8'h00;
		pattern_energy_sum = 17'h0;
		inner_ring_energy_sum = 17'h0;
		outer_ring_energy_sum = 17'h0;
		locmax = 1'b1;
		for (int i = 0; i < 25; i++) begin
			if (pix_dead[i]) begin
				corr[i] = 12'h000;
			end else if (pix_nbhd[i] > state_reg.ofs) begin
				corr[i] = pix_nbhd[i] - state_reg.ofs;
			end else begin
				corr[i] = 12'h000;
			end
			hit[i] = corr[i] > state_reg.thr;
		end
		for (int i = 0; i < 25; i++) begin
			if (i != CEDF_CENTER) begin
				if (hit[i] && corr[i] > corr[CEDF_CENTER]) begin
					locmax = 1'b0;
				end
				if (is_inner(i)) begin
					sig[k] = hit[i];
					if (hit[i]) begin
						pattern_energy_sum = pattern_energy_sum + 17'(corr[i]);
					end else begin
						inner_ring_energy_sum = inner_ring_energy_sum + 17'(corr[i]);
					end
					k = k + 1;
				end else begin
					outer_ring_energy_sum = outer_ring_energy_sum + 17'(corr[i]);
				end
			end
		end
		code = CEDF_UNCLASS;
		for (int j = CEDF_NPAT - 1; j >= 0; j--) begin
			if (state_reg.pat[j][8] && state_reg.pat[j][7:0] == sig) begin
				code = 5'(j);
			end
		end
		// Dead centre never qualifies, whatever its raw value
		qual = pix_qual && !pix_dead[CEDF_CENTER] && hit[CEDF_CENTER];
		// Checkout lets tracks and duplicates through for diagnosis
		keep = qual && (chk || (locmax && code != CEDF_UNCLASS));
	end

	// Word formatting and sequencing
	always_comb begin
		logic [20:0] p;
		logic [16:0] a;
		logic [16:0] b;
		logic [16:0] c;
		p = ovs ? {pix_x, pix_y} : {1'b0, pix_x[9:0], pix_y};
		a = sat(pattern_energy_sum, len80 ? 14 : 9);
		b = sat(inner_ring_energy_sum, len80 ? 13 : 8);
		c = sat(outer_ring_energy_sum, len80 ? 14 : 8);
		ld = 1'b0;
		ldw = 80'h0;
		ldst = CEDF_IDLE;
		state_next = state_reg;
		state_next.sstart = 1'b0;
		state_next.rdata = 32'h0;
		state_next.tmr = state_reg.tmr + 32'h1;
		case (state_reg.st)
			CEDF_IDLE: begin
				if (acc_start) begin
					state_next.chip = chip_id;
					state_next.evc = 16'h0;
					ld = 1'b1;
					ldst = CEDF_HDR;
					// Window fields are 21 bits wide with overscan and 20 bits without
					if (ovs) begin
						ldw = {1'b1, chip_id, state_reg.ctrl[2:0], state_reg.wpos,
							state_reg.wsz, 31'h0};
					end else begin
						ldw = {1'b1, chip_id, state_reg.ctrl[2:0], state_reg.wpos[19:0],
							state_reg.wsz[19:0], 33'h0};
					end
				end
			end
			CEDF_RUN: begin
				if (acc_end) begin
					ld = 1'b1;
					ldst = CEDF_TRL;
					ldw = {1'b1, state_reg.chip, CEDF_TRL_MODE, state_reg.tmr,
						state_reg.evc, 25'h0};
				end else if (acc_pix) begin
					if (qual) begin
						state_next.evc = state_reg.evc + 16'h1;
					end
					if (keep) begin
						ld = 1'b1;
						ldst = CEDF_EVT;
						if (len80) begin
							ldw = ovs ? {1'b0, p, code, a[13:0], b[12:0], c[13:0],
								corr[CEDF_CENTER]}
								: {1'b0, p[19:0], code, a[13:0], b[12:0], c[13:0],
								corr[CEDF_CENTER], 1'b0};
						end else begin
							ldw = ovs ? {1'b0, p, code, a[8:0], b[7:0], c[7:0],
								corr[CEDF_CENTER], 16'h0}
								: {1'b0, p[19:0], code, a[8:0], b[7:0], c[7:0],
								corr[CEDF_CENTER], 17'h0};
						end
					end
				end
			end
			default: begin
				state_next.sh = state_reg.sh << 1;
				state_next.sdata = state_reg.sh[78];
				state_next.cnt = state_reg.cnt + 7'h01;
				if (state_reg.cnt == lenm1) begin
					state_next.sframe = 1'b0;
					state_next.sdata = 1'b0;
					state_next.rdy = 1'b1;
					state_next.st = (state_reg.st == CEDF_TRL) ? CEDF_IDLE : CEDF_RUN;
				end
			end
		endcase
		if (ld) begin
			state_next.st = ldst;
			state_next.sh = ldw;
			state_next.cnt = 7'h00;
			state_next.sdata = ldw[79];
			state_next.sframe = 1'b1;
			state_next.sstart = 1'b1;
			state_next.rdy = 1'b0;
		end
		// Format bits take effect on the next cycle, even in the middle of a word
		if (reg_wr) begin
			if (8'(reg_addr) == CEDF_REG_CTRL) begin
				state_next.ctrl = reg_wdata[5:0];
			end else if (8'(reg_addr) == CEDF_REG_THRESH) begin
				state_next.thr = reg_wdata[11:0];
			end else if (8'(reg_addr) == CEDF_REG_OFFSET) begin
				state_next.ofs = reg_wdata[11:0];
			end else if (8'(reg_addr) == CEDF_REG_WINPOS) begin
				state_next.wpos = reg_wdata[20:0];
			end else if (8'(reg_addr) == CEDF_REG_WINSIZE) begin
				state_next.wsz = reg_wdata[20:0];
			end else if (psel[5]) begin
				state_next.pat[psel[4:0]] = reg_wdata[8:0];
			end
		end
		if (reg_rd) begin
			if (8'(reg_addr) == CEDF_REG_CTRL) begin
				state_next.rdata = {26'h0, state_reg.ctrl};
			end else if (8'(reg_addr) == CEDF_REG_THRESH) begin
				state_next.rdata = {20'h0, state_reg.thr};
			end else if (8'(reg_addr) == CEDF_REG_OFFSET) begin
				state_next.rdata = {20'h0, state_reg.ofs};
			end else if (8'(reg_addr) == CEDF_REG_WINPOS) begin
				state_next.rdata = {11'h0, state_reg.wpos};
			end else if (8'(reg_addr) == CEDF_REG_WINSIZE) begin
				state_next.rdata = {11'h0, state_reg.wsz};
			end else if (8'(reg_addr) == CEDF_REG_STATUS) begin
				state_next.rdata = {13'h0, 3'(state_reg.st), state_reg.evc};
			end else if (8'(reg_addr) == CEDF_REG_TIMER) begin
				state_next.rdata = state_reg.tmr;
			end else if (psel[5]) begin
				state_next.rdata = {23'h0, state_reg.pat[psel[4:0]]};
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_reg <= '0;
			state_reg.st <= CEDF_IDLE;
			state_reg.rdy <= 1'b1;
			state_reg.ctrl <= CEDF_CTRL_RST;
			state_reg.thr <= CEDF_THRESH_RST;
			state_reg.ofs <= CEDF_OFFSET_RST;
		end else begin
			state_reg <= state_next;
		end
	end

	assign reg_rdata = state_reg.rdata;
	assign in_ready = state_reg.rdy;
	assign ser_data = state_reg.sdata;
	assign ser_frame = state_reg.sframe;
	assign ser_start = state_reg.sstart;

	property p_hdr_first;
		@(posedge clock) disable iff (rst)
		acc_start |=> state_reg.st == CEDF_HDR && ser_start && ser_data;
	endproperty
	a_hdr_first: assert property (p_hdr_first) else $error("header not sent first");

	property p_evt_id;
		@(posedge clock) disable iff (rst)
		(acc_pix && keep) |=> state_reg.st == CEDF_EVT && ser_start && !ser_data;
	endproperty
	a_evt_id: assert property (p_evt_id) else $error("event word id wrong");

	property p_len64;
		@(posedge clock) disable iff (rst)
		(ser_start && !len80) |-> ##62 ser_frame ##1 (ser_frame && !ser_start) ##1 !ser_frame;
	endproperty
	a_len64: assert property (p_len64) else $error("64-bit word length wrong");

	property p_len80;
		@(posedge clock) disable iff (rst)
		(ser_start && len80) |-> ##78 ser_frame ##1 ser_frame ##1 !ser_frame;
	endproperty
	a_len80: assert property (p_len80) else $error("80-bit word length wrong");

	property p_thresh;
		@(posedge clock) disable iff (rst)
		(acc_pix && !hit[CEDF_CENTER]) |=> state_reg.st == CEDF_RUN && $stable(state_reg.evc);
	endproperty
	a_thresh: assert property (p_thresh) else $error("sub-threshold pixel used");

	property p_dead;
		@(posedge clock) disable iff (rst)
		(acc_pix && pix_dead[CEDF_CENTER]) |=> state_reg.st != CEDF_EVT;
	endproperty
	a_dead: assert property (p_dead) else $error("dead pixel produced event");

	property p_locmax;
		@(posedge clock) disable iff (rst)
		(acc_pix && !chk && !locmax) |=> state_reg.st != CEDF_EVT;
	endproperty
	a_locmax: assert property (p_locmax) else $error("non-maximum centre sent");

	property p_trailer;
		@(posedge clock) disable iff (rst)
		acc_end |=> state_reg.st == CEDF_TRL && ser_start
			&& state_reg.sh[40:25] == $past(state_reg.evc);
	endproperty
	a_trailer: assert property (p_trailer) else $error("trailer missing count");

	property p_ready;
		@(posedge clock) disable iff (rst)
		ser_frame |-> !in_ready;
	endproperty
	a_ready: assert property (p_ready) else $error("ready while shifting");
endmodule

// *** dv/cedf_dhu_model.sv ***
// Receiving end of the serial word line: collects each framed word.
// Assumes ser_start marks the first bit and ser_frame spans the word.
`timescale 1ns/1ps
module cedf_dhu_model (
	input wire logic clock,
	input wire logic rst,
	input wire logic ser_data,
	input wire logic ser_frame,
	input wire logic ser_start,
	output logic [79:0] word_reg,
	output logic [6:0] nbits_reg,
	output int nwords,
	output int bad
);
	logic [79:0] sh;
	logic [6:0] n;
	logic fr_d;
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			sh <= '0;
			n <= '0;
			fr_d <= 1'b0;
			word_reg <= '0;
			nbits_reg <= '0;
			nwords <= 0;
			bad <= 0;
		end else begin
			fr_d <= ser_frame;
			// MSB first; a fresh word restarts on its start pulse
			if (ser_frame) begin
				sh <= ser_start ? {79'h0, ser_data} : {sh[78:0], ser_data};
				n <= ser_start ? 7'h01 : n + 7'h01;
			end
			// Realign on the counted bit total at the end of framing
			if (fr_d && !ser_frame) begin
				word_reg <= sh << (7'h50 - n);
				nbits_reg <= n;
				nwords <= nwords + 1;
			end
			if ((ser_start && !ser_frame) || (ser_frame && !fr_d && !ser_start) ||
				(!ser_frame && ser_data)) begin
				bad <= bad + 1;
			end
		end
	end
endmodule

// *** dv/test_cedf_framer.sv ***
// Self-checking bench for the event detector and serial word framer.
// Assumes the receiving model on the serial line and a 250 MHz clock.
`timescale 1ns/1ps
module test_cedf_framer import cedf_pkg::*;;
	localparam logic [79:0] ALL = {80{1'b1}};
	localparam logic [79:0] TMASK = {7'h7F, 32'h0, 41'h1FFFFFFFFFF};
	logic clock, rst, reg_wr, reg_rd, frame_start, frame_end, pix_valid, pix_qual;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	logic [2:0] chip_id;
	logic [10:0] pix_x;
	logic [9:0] pix_y;
	logic [24:0][11:0] pix_nbhd, extra;
	logic [24:0] pix_dead, dead_v;
	logic in_ready, ser_data, ser_frame, ser_start;
	logic [79:0] word_reg;
	logic [6:0] nbits_reg;
	int nwords, bad, nexp, mismatches, cmp_count;

	cedf_framer u_cedf_framer (.clock(clock), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.frame_start(frame_start), .chip_id(chip_id), .frame_end(frame_end),
		.pix_valid(pix_valid), .pix_qual(pix_qual), .pix_x(pix_x), .pix_y(pix_y),
		.pix_nbhd(pix_nbhd), .pix_dead(pix_dead), .in_ready(in_ready),
		.ser_data(ser_data), .ser_frame(ser_frame), .ser_start(ser_start));
	cedf_dhu_model u_cedf_dhu_model (.clock(clock), .rst(rst), .ser_data(ser_data),
		.ser_frame(ser_frame), .ser_start(ser_start), .word_reg(word_reg),
		.nbits_reg(nbits_reg), .nwords(nwords), .bad(bad));

	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	task automatic results;
		$display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmp80(input logic [79:0] got, input logic [79:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 cmp32(reg_rdata, e);
	endtask

	task automatic ctl(input logic s, input logic e, input logic [2:0] c);
		@(posedge clock);
		frame_start <= s;
		frame_end <= e;
		chip_id <= c;
		@(posedge clock);
		frame_start <= 1'b0;
		frame_end <= 1'b0;
	endtask

	// Centre plus one chosen neighbour, on top of the extra pattern
	task automatic pix(input logic [10:0] x, input logic [9:0] y, input logic [11:0] c,
		input int i, input logic [11:0] v, input logic q);
		logic [24:0][11:0] n;
		n = extra;
		n[i] = v;
		n[12] = c;
		@(posedge clock);
		pix_nbhd <= n;
		pix_dead <= dead_v;
		pix_x <= x;
		pix_y <= y;
		pix_qual <= q;
		pix_valid <= 1'b1;
		@(posedge clock);
		pix_valid <= 1'b0;
	endtask

	task automatic expw(input logic [79:0] e, input int len, input logic [79:0] m);
		int k;
		k = 0;
		while (nwords != nexp + 1 && k < 200) begin
			@(posedge clock);
			#1 k++;
		end
		nexp++;
		cmp80(word_reg & m, e & m);
		cmp32({25'h0, nbits_reg}, len);
	endtask

	task automatic nowrd;
		repeat (5) @(posedge clock);
		#1 cmp32(nwords, nexp);
		cmp32({31'h0, in_ready}, 32'h1);
	endtask

	initial begin
		repeat (20000) @(posedge clock);
		mismatches++;
		results;
	end

	initial begin
		{reg_wr, reg_rd, frame_start, frame_end, pix_valid, pix_qual} = '0;
		{reg_addr, reg_wdata, chip_id, pix_x, pix_y} = '0;
		{pix_nbhd, extra, pix_dead, dead_v} = '0;
		{nexp, mismatches, cmp_count} = '0;
		rst = 1'b1;
		repeat (6) @(posedge clock);
		rst <= 1'b0;
		rd(CEDF_REG_THRESH, 32'h0);
		wr(CEDF_REG_THRESH, 32'h0000000A);
		wr(CEDF_REG_WINPOS, 32'h000ABCDE);
		wr(CEDF_REG_WINSIZE, 32'h00112345);
		wr(CEDF_REG_PAT, 32'h00000100);
		wr(CEDF_REG_PAT + 8'h04, 32'h00000102);
		wr(CEDF_REG_PAT + 8'h08, 32'h00000101);
		wr(8'h3C, 32'h0000FFFF);
		rd(8'h3C, 32'h0);
		rd(CEDF_REG_PAT + 8'h04, 32'h00000102);
		rd(CEDF_REG_THRESH, 32'h0000000A);
		wr(CEDF_REG_CTRL, 32'h00000003);
		ctl(1'b1, 1'b0, 3'h5);
		expw({1'b1, 3'h5, 3'h3, 20'hABCDE, 20'h12345, 33'h0}, 64, ALL);
		pix(11'h123, 10'h045, 12'd100, 0, 12'd0, 1'b1);
		expw({1'b0, 10'h123, 10'h045, 5'h00, 25'h0, 12'd100, 17'h0}, 64, ALL);
		pix(11'h010, 10'h020, 12'd50, 6, 12'd60, 1'b1);
		nowrd;
		pix(11'h011, 10'h020, 12'd100, 0, 12'd0, 1'b0);
		nowrd;
		dead_v = 25'h0001000;
		pix(11'h012, 10'h020, 12'd100, 0, 12'd0, 1'b1);
		nowrd;
		dead_v = '0;
		// Exactly at threshold must not qualify
		pix(11'h013, 10'h020, 12'd10, 0, 12'd0, 1'b1);
		nowrd;
		ctl(1'b0, 1'b1, 3'h0);
		expw({1'b1, 3'h5, 3'h7, 32'h0, 16'd2, 25'h0}, 64, TMASK);
		rd(CEDF_REG_STATUS, 32'h00000002);
		wr(CEDF_REG_CTRL, 32'h0000003E);
		wr(CEDF_REG_OFFSET, 32'h00000005);
		ctl(1'b1, 1'b0, 3'h2);
		expw({1'b1, 3'h2, 3'h6, 21'h0ABCDE, 21'h112345, 31'h0}, 80, ALL);
		extra[6] = 12'd8;
		extra[0] = 12'd9;
		extra[24] = 12'd100;
		dead_v = 25'h1000000;
		pix(11'h523, 10'h045, 12'd205, 7, 12'd35, 1'b1);
		expw({1'b0, 11'h523, 10'h045, 5'h01, 14'd30, 13'd3, 14'd4, 12'd200}, 80, ALL);
		extra = '0;
		dead_v = '0;
		pix(11'h001, 10'h002, 12'd155, 8, 12'd45, 1'b1);
		expw({1'b0, 11'h001, 10'h002, 5'h1F, 14'd40, 13'd0, 14'd0, 12'd150}, 80, ALL);
		ctl(1'b0, 1'b1, 3'h0);
		expw({1'b1, 3'h2, 3'h7, 32'h0, 16'd2, 25'h0}, 80, TMASK);
		// Short words with overscan, no checkout: unclassified dropped, pattern sum saturates
		wr(CEDF_REG_CTRL, 32'h00000010);
		ctl(1'b1, 1'b0, 3'h1);
		expw({1'b1, 3'h1, 3'h0, 21'h0ABCDE, 21'h112345, 31'h0}, 64, ALL);
		pix(11'h004, 10'h005, 12'd155, 8, 12'd45, 1'b1);
		nowrd;
		pix(11'h523, 10'h045, 12'd700, 7, 12'd605, 1'b1);
		expw({1'b0, 11'h523, 10'h045, 5'h01, 9'h1FF, 8'h00, 8'h00, 12'd695, 16'h0}, 64, ALL);
		ctl(1'b0, 1'b1, 3'h0);
		expw({1'b1, 3'h1, 3'h7, 32'h0, 16'd2, 25'h0}, 64, TMASK);
		rd(CEDF_REG_WINPOS, 32'h000ABCDE);
		// Long words without overscan, checkout passes a non-maximum centre
		wr(CEDF_REG_CTRL, 32'h0000002D);
		ctl(1'b1, 1'b0, 3'h4);
		expw({1'b1, 3'h4, 3'h5, 20'hABCDE, 20'h12345, 33'h0}, 80, ALL);
		pix(11'h7FF, 10'h3FF, 12'd50, 6, 12'd60, 1'b1);
		expw({1'b0, 10'h3FF, 10'h3FF, 5'h02, 14'd55, 13'd0, 14'd0, 12'd45, 1'b0}, 80, ALL);
		ctl(1'b0, 1'b1, 3'h0);
		expw({1'b1, 3'h4, 3'h7, 32'h0, 16'd1, 25'h0}, 80, TMASK);
		cmp32(bad, 32'h0);
		results;
	end
endmodule
